// ---- bench/lpmc_monitor.sv ----
// Purpose: mode and pin relations of the mode controller
// Assumes: state codes 0..B as the design reports on o_mode
// Notes: bound to lpmc_top below
`timescale 1ns/1ns
module lpmc_monitor (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [3:0] o_mode,
  input wire o_fast_osc_en,
  input wire o_slow_osc_en,
  input wire o_cpu_run,
  input wire o_wdt_run,
  input wire o_periph_clk_en,
  input wire o_time_base_clk_en,
  input wire o_div_low_run,
  input wire o_port_out_en,
  input wire o_stop_pin_oe,
  input wire [7:0] o_port_in_val,
  input wire o_time_base_irq,
  input wire o_time_base_irq_latch
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_tg_exit; o_mode == 4'h9 ##1 o_mode != 4'h9; endsequence
  sequence s_sl1_exit; o_mode == 4'h6 ##1 o_mode != 4'h6; endsequence
  sequence s_warm_end; o_mode == 4'hB ##1 o_mode != 4'hB; endsequence
  property p_stop_osc; o_mode == 4'hA |-> !o_fast_osc_en && !o_slow_osc_en && !o_cpu_run; endproperty
  property p_stop_pin; o_mode == 4'hA |-> !o_stop_pin_oe; endproperty
  property p_low_freq_sleep_one; o_mode == 4'h6 |-> o_slow_osc_en && !o_fast_osc_en && !o_cpu_run && !o_wdt_run; endproperty
  property p_low_freq_sleep_two; o_mode == 4'h7 |-> o_slow_osc_en && o_fast_osc_en && !o_cpu_run; endproperty
  property p_div; (o_mode == 4'h3 || o_mode == 4'h6) |-> !o_div_low_run; endproperty
  property p_tg_gate; o_mode == 4'h9 |-> o_time_base_clk_en && !o_periph_clk_en && !o_cpu_run; endproperty
  property p_tg_exit; s_tg_exit |-> o_mode == 4'h3; endproperty
  property p_sl1_exit; s_sl1_exit |-> o_mode == 4'h3; endproperty
  property p_warm_end; s_warm_end |-> o_mode == 4'h0 || o_mode == 4'h1 || o_mode == 4'h3; endproperty
  property p_in_zero; (o_mode == 4'hA && !o_port_out_en)[*2] |-> o_port_in_val == 8'h00; endproperty
  property p_irq; o_time_base_irq |-> o_time_base_irq_latch; endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator running in stop");
  a_stop_pin: assert property (p_stop_pin) else $error("stop pin driven in stop");
  a_low_freq_sleep_one: assert property (p_low_freq_sleep_one) else $error("sleep one outputs wrong");
  a_low_freq_sleep_two: assert property (p_low_freq_sleep_two) else $error("sleep two outputs wrong");
  a_div: assert property (p_div) else $error("low divider running");
  a_tg_gate: assert property (p_tg_gate) else $error("timer-gated clocks wrong");
  a_tg_exit: assert property (p_tg_exit) else $error("timer-gated exit not slow one");
  a_sl1_exit: assert property (p_sl1_exit) else $error("sleep one exit not slow one");
  a_warm_end: assert property (p_warm_end) else $error("warm-up ended in odd mode");
  a_in_zero: assert property (p_in_zero) else $error("port inputs not forced low");
  a_irq: assert property (p_irq) else $error("irq without latch");
endmodule
bind lpmc_top lpmc_monitor u_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_mode(o_mode),
  .o_fast_osc_en(o_fast_osc_en), .o_slow_osc_en(o_slow_osc_en), .o_cpu_run(o_cpu_run), .o_wdt_run(o_wdt_run),
  .o_periph_clk_en(o_periph_clk_en), .o_time_base_clk_en(o_time_base_clk_en), .o_div_low_run(o_div_low_run),
  .o_port_out_en(o_port_out_en), .o_stop_pin_oe(o_stop_pin_oe), .o_port_in_val(o_port_in_val),
  .o_time_base_irq(o_time_base_irq), .o_time_base_irq_latch(o_time_base_irq_latch));

// ---- bench/lpmc_tb.sv ----
// Purpose: scenario tests of the mode controller
// Assumes: clock enables pulse every cycle to keep warm-up short
// Notes: AXI4-Lite master tasks, no partner model
`timescale 1ns/1ns
`include "lpmc_consts.vh"
module testbench;
  logic i_clk = 0, i_sys_rst = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic tb_src = 0, stop_pin = 0, key = 0, irq = 0;
  logic [7:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, rd;
  logic [1:0] rsp;
  wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, fosc, sosc, cpu, wdt, per, tbc, div, pout, spoe, tirq, tlat;
  wire [1:0] b_rsp, r_rsp;
  wire [31:0] r_d;
  wire [7:0] pin_val;
  wire [3:0] mode;
  int mismatches = 0, n_tests = 0, cnt;
  lpmc_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .i_fast_clk_en(1'b1), .i_slow_clk_en(1'b1), .i_time_base_src(tb_src), .i_stop_pin(stop_pin),
    .i_key_wakeup(key), .i_irq_req(irq), .i_port_in(8'hA5), .o_fast_osc_en(fosc), .o_slow_osc_en(sosc),
    .o_cpu_run(cpu), .o_wdt_run(wdt), .o_periph_clk_en(per), .o_time_base_clk_en(tbc), .o_div_low_run(div),
    .o_port_out_en(pout), .o_stop_pin_oe(spoe), .o_port_in_val(pin_val), .o_time_base_irq_latch(tlat),
    .o_time_base_irq(tirq), .o_mode(mode));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    aw_a <= a; w_d <= d; aw_v <= 1; w_v <= 1; b_r <= 1;
    forever begin
      @(posedge i_clk);
      if (aw_rdy && !aw) begin aw = 1; aw_v <= 0; end
      if (w_rdy && !w) begin w = 1; w_v <= 0; end
      if (b_v) break;
    end
    r = b_rsp;
    b_r <= 0;
    @(posedge i_clk);
  endtask
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ar_a <= a; ar_v <= 1; r_r <= 1;
    forever begin
      @(posedge i_clk);
      if (ar_rdy) ar_v <= 0;
      if (r_v) break;
    end
    d = r_d;
    r = r_rsp;
    r_r <= 0;
    @(posedge i_clk);
  endtask
  task automatic wait_mode(input logic [3:0] m);
    int n;
    for (n = 0; n < 60 && mode !== m; n++) @(posedge i_clk);
    chk("mode", mode, m);
  endtask
  task automatic go(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
    wr(a, d, rsp);
    wait_mode(m);
  endtask
  task automatic warm(input int n, input logic [3:0] m);
    wait_mode(4'hB);
    for (cnt = 0; cnt < 20000 && mode === 4'hB; cnt++) @(posedge i_clk);
    chk("warm-up length ok", cnt >= n - 2 && cnt <= n + 4, 1);
    wait_mode(m);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdw(`LPMC_ADDR_STOP_CTRL, rd, rsp);
    chk("stop ctrl reset", rd, 32'h0000_0000);
    chk("port inputs pass", pin_val, 8'hA5);
    wr(`LPMC_ADDR_STOP_CTRL, 32'h0000_000F, rsp);
    rdw(`LPMC_ADDR_STOP_CTRL, rd, rsp);
    chk("stop ctrl low bits", rd, 32'h0000_000C);
    rdw(8'h50, rd, rsp);
    chk("unmapped read resp", rsp, `LPMC_RESP_SLVERR);
    wr(8'h50, 32'h0000_0001, rsp);
    chk("unmapped write resp", rsp, `LPMC_RESP_SLVERR);
  endtask
  task automatic t_stop_edge;
    go(`LPMC_ADDR_STOP_CTRL, 32'h0000_008C, 4'hA);
    repeat (3) @(posedge i_clk);
    chk("tristate pins", {pout, spoe, pin_val}, 10'h000);
    key <= 1;
    repeat (10) @(posedge i_clk);
    chk("key ignored in edge mode", mode, 4'hA);
    key <= 0;
    stop_pin <= 1;
    warm(16384, 4'h0);
    rdw(`LPMC_ADDR_STOP_CTRL, rd, rsp);
    chk("stop bit cleared", rd, 32'h0000_000C);
    stop_pin <= 0;
  endtask
  task automatic t_sleep;
    go(`LPMC_ADDR_MODE_TWO, 32'h0000_00C0, 4'h1);
    go(`LPMC_ADDR_MODE_TWO, 32'h0000_00E0, 4'h2);
    go(`LPMC_ADDR_MODE_TWO, 32'h0000_00F0, 4'h7);
    chk("sleep two osc", {fosc, sosc, cpu}, 3'b110);
    irq <= 1;
    wait_mode(4'h2);
    irq <= 0;
    go(`LPMC_ADDR_MODE_TWO, 32'h0000_0060, 4'h3);
    chk("slow one divider", {fosc, div}, 2'b00);
    go(`LPMC_ADDR_MODE_TWO, 32'h0000_0070, 4'h6);
    chk("sleep one outs", {fosc, sosc, cpu, wdt, per, div}, 6'b010010);
    irq <= 1;
    wait_mode(4'h3);
    irq <= 0;
    rdw(`LPMC_ADDR_MODE_TWO, rd, rsp);
    chk("idle bit cleared", rd, 32'h0000_0060);
  endtask
  task automatic t_tg;
    tb_src <= 1;
    wr(`LPMC_ADDR_TIME_BASE, 32'h0000_0038, rsp);
    go(`LPMC_ADDR_MODE_TWO, 32'h0000_0064, 4'h9);
    chk("gated clocks", {tbc, per, cpu}, 3'b100);
    repeat (10) @(posedge i_clk);
    chk("no wake without fall", mode, 4'h9);
    tb_src <= 0;
    wait_mode(4'h3);
    rdw(`LPMC_ADDR_MODE_TWO, rd, rsp);
    chk("halt bit cleared", rd, 32'h0000_0060);
    rdw(`LPMC_ADDR_STATUS, rd, rsp);
    chk("latch set", rd, 32'h0000_0031);
    chk("irq out", tirq, 1'b1);
    wr(`LPMC_ADDR_STATUS, 32'h0000_0001, rsp);
    chk("latch clear", tlat, 1'b0);
  endtask
  task automatic t_stop_level;
    go(`LPMC_ADDR_STOP_CTRL, 32'h0000_00F8, 4'hA);
    repeat (3) @(posedge i_clk);
    chk("ports kept", {pout, spoe, pin_val}, 10'h2A5);
    key <= 1;
    warm(192, 4'h3);
    key <= 0;
    stop_pin <= 1;
    repeat (6) @(posedge i_clk);
    wr(`LPMC_ADDR_STOP_CTRL, 32'h0000_00EC, rsp);
    chk("warm-up at once with pin high", mode, 4'hB);
    cnt = 0;
    repeat (20) begin
      @(posedge i_clk);
      if (mode === 4'hA) cnt++;
    end
    chk("no stop with pin high", cnt, 0);
    wait_mode(4'h3);
    stop_pin <= 0;
  endtask
  task automatic t_reset_stop;
    repeat (6) @(posedge i_clk);
    go(`LPMC_ADDR_STOP_CTRL, 32'h0000_00A0, 4'hA);
    i_sys_rst <= 1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 0;
    @(posedge i_clk);
    chk("reset exit mode", mode, 4'h0);
    rdw(`LPMC_ADDR_STOP_CTRL, rd, rsp);
    chk("reset exit reg", rd, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 0;
    @(posedge i_clk);
    t_regs();
    t_stop_edge();
    t_sleep();
    t_tg();
    t_stop_level();
    t_reset_stop();
    wrap_up();
  end
endmodule

// ---- design/lpmc_consts.vh ----
// Purpose: constants for the low-power mode controller
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes: definitions only
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH
`define LPMC_ADDR_STOP_CTRL 8'h38
`define LPMC_ADDR_MODE_TWO 8'h3C
`define LPMC_ADDR_TIME_BASE 8'h40
`define LPMC_ADDR_STATUS 8'h44
`define LPMC_STOP_CTRL_RST 8'h00
`define LPMC_MODE_TWO_RST 8'h80
`define LPMC_BIT_STOP 7
`define LPMC_BIT_RELEASE_METHOD 6
`define LPMC_BIT_RETURN_MODE 5
`define LPMC_BIT_HOLD 4
`define LPMC_BIT_WUT_HI 3
`define LPMC_BIT_WUT_LO 2
`define LPMC_BIT_XEN 7
`define LPMC_BIT_XTEN 6
`define LPMC_BIT_SYSCK 5
`define LPMC_BIT_IDLE 4
`define LPMC_BIT_TIMING_GEN_HALT 2
`define LPMC_BIT_TBEN 3
`define LPMC_BIT_TBIE 4
`define LPMC_BIT_MIE 5
`define LPMC_WU_NORM_00 24'h030000
`define LPMC_WU_NORM_01 24'h010000
`define LPMC_WU_NORM_10 24'h00C000
`define LPMC_WU_NORM_11 24'h004000
`define LPMC_WU_SLOW_00 24'h006000
`define LPMC_WU_SLOW_01 24'h002000
`define LPMC_WU_SLOW_10 24'h0000C0
`define LPMC_WU_SLOW_11 24'h000040
`define LPMC_RESP_OKAY 2'h0
`define LPMC_RESP_SLVERR 2'h2
`endif

// ---- design/lpmc_top.v ----
// Purpose: operating-mode controller: sleep, timer-gated sleep and STOP
// Assumes: fast/slow clocks arrive as enable pulses; pins are asynchronous
// Notes: AXI4-Lite slave, single clock domain
// Notes on behaviour
// [R1] Sleep one: slow osc on, CPU/watchdog/fast osc off
// [R2] Sleep one enters like idle, returns slow
// [R3] Slow/sleep one stop divider stages one-six
// [R4] Sleep two keeps fast oscillator running
// [R5] Halt bit in slow enters timer-gated sleep
// [R6] Only time base clocked; wake on falling edge
// [R7] Timer-gated sleep exits to first slow mode
// [R8] Entry independent of enable; irq needs three enables
// [R9] Enabled timer sets time-base latch after exit
// [R10] Stop bit halts oscillators, holds state
// [R11] Stop pin releases, resume after warm-up
// [R12] Release method bit: edge or level
// [R13] Return mode bit: normal or slow
// [R14] Port hold bit: tristate or keep outputs
// [R15] Warm-up field selects count per return mode
// [R16] Software sets return mode matching entry
// [R17] Reset pin exit always gives first normal
// [R18] Stop register bits zero/one read undefined
// [R19] Tristated ports force inputs to zero
// [R20] Key wake-up needs level-sensitive release
// [R21] Shared stop pin tristated during STOP
// [R22] Interrupt request ends idle or sleep
// [R23] Timer-gated release clears halt bit
// [R24] Level release with pin high skips stop
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "lpmc_consts.vh"
module lpmc_top (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire i_fast_clk_en,
  input wire i_slow_clk_en,
  input wire i_time_base_src,
  input wire i_stop_pin,
  input wire i_key_wakeup,
  input wire i_irq_req,
  input wire [7:0] i_port_in,
  output reg o_fast_osc_en,
  output reg o_slow_osc_en,
  output reg o_cpu_run,
  output reg o_wdt_run,
  output reg o_periph_clk_en,
  output reg o_time_base_clk_en,
  output reg o_div_low_run,
  output reg o_port_out_en,
  output reg o_stop_pin_oe,
  output reg [7:0] o_port_in_val,
  output reg o_time_base_irq_latch,
  output reg o_time_base_irq,
  output reg [3:0] o_mode
);
  localparam ST_NORM1 = 4'h0;
  localparam ST_NORM2 = 4'h1;
  localparam ST_SLOW_FAST_OSC_ON = 4'h2;
  localparam ST_SLOW_FAST_OSC_OFF = 4'h3;
  localparam ST_FIRST_IDLE = 4'h4;
  localparam ST_SECOND_IDLE = 4'h5;
  localparam ST_SLP1 = 4'h6;
  localparam ST_SLP2 = 4'h7;
  localparam ST_TGIDLE = 4'h8;
  localparam ST_TGSLP = 4'h9;
  localparam ST_STOP = 4'hA;
  localparam ST_WARM = 4'hB;

  function [23:0] wu_count;
    input [1:0] sel;
    input to_slow;
    begin
      case ({to_slow, sel})
        3'h0: wu_count = `LPMC_WU_NORM_00;
        3'h1: wu_count = `LPMC_WU_NORM_01;
        3'h2: wu_count = `LPMC_WU_NORM_10;
        3'h3: wu_count = `LPMC_WU_NORM_11;
        3'h4: wu_count = `LPMC_WU_SLOW_00;
        3'h5: wu_count = `LPMC_WU_SLOW_01;
        3'h6: wu_count = `LPMC_WU_SLOW_10;
        default: wu_count = `LPMC_WU_SLOW_11;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change counts once stages two and three agree
  reg [2:0] stop_sync_ff;
  reg [2:0] key_sync_ff;
  reg [2:0] irq_sync_ff;
  reg [2:0] tb_sync_ff;
  reg stop_lvl_ff;
  reg key_lvl_ff;
  reg irq_lvl_ff;
  reg tb_lvl_ff;
  reg [7:0] port_s1_ff;
  reg [7:0] port_s2_ff;
  reg [7:0] port_s3_ff;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      stop_sync_ff <= 3'h0;
      key_sync_ff <= 3'h0;
      irq_sync_ff <= 3'h0;
      tb_sync_ff <= 3'h0;
      stop_lvl_ff <= 1'b0;
      key_lvl_ff <= 1'b0;
      irq_lvl_ff <= 1'b0;
      tb_lvl_ff <= 1'b0;
      port_s1_ff <= 8'h00;
      port_s2_ff <= 8'h00;
      port_s3_ff <= 8'h00;
    end else begin
      stop_sync_ff <= {stop_sync_ff[1:0], i_stop_pin};
      key_sync_ff <= {key_sync_ff[1:0], i_key_wakeup};
      irq_sync_ff <= {irq_sync_ff[1:0], i_irq_req};
      tb_sync_ff <= {tb_sync_ff[1:0], i_time_base_src};
      port_s1_ff <= i_port_in;
      port_s2_ff <= port_s1_ff;
      port_s3_ff <= port_s2_ff;
      if (stop_sync_ff[1] == stop_sync_ff[2])
        stop_lvl_ff <= stop_sync_ff[2];
      if (key_sync_ff[1] == key_sync_ff[2])
        key_lvl_ff <= key_sync_ff[2];
      if (irq_sync_ff[1] == irq_sync_ff[2])
        irq_lvl_ff <= irq_sync_ff[2];
      if (tb_sync_ff[1] == tb_sync_ff[2])
        tb_lvl_ff <= tb_sync_ff[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and mode state
  reg [7:0] stop_ctrl_ff;
  reg [7:0] mode_two_ff;
  reg [7:0] time_base_ff;
  reg [3:0] state_ff;
  reg [23:0] warm_cnt_ff;
  reg warm_slow_ff;
  reg tb_armed_ff;
  reg tb_prev_ff;
  reg stop_prev_ff;
  reg set_tb_latch;
  reg [7:0] wr_addr_ff;
  reg [31:0] wr_data_ff;
  reg [3:0] wr_strb_ff;
  reg aw_have_ff;
  reg w_have_ff;
  wire wr_fire = aw_have_ff && w_have_ff && !s_axi_bvalid;

  wire tb_fall = tb_prev_ff && !tb_lvl_ff;
  wire stop_rise = !stop_prev_ff && stop_lvl_ff;
  wire level_rel = stop_ctrl_ff[`LPMC_BIT_RELEASE_METHOD];
  // Key wake-up is honoured only with level release; software must not mix them
  wire stop_release = level_rel ? (stop_lvl_ff || key_lvl_ff) : stop_rise; // [R11] [R12] [R20]
  wire wr_stop_ctrl = wr_fire && (wr_addr_ff == `LPMC_ADDR_STOP_CTRL) && wr_strb_ff[0];
  wire wr_mode_two = wr_fire && (wr_addr_ff == `LPMC_ADDR_MODE_TWO) && wr_strb_ff[0];
  wire wr_time_base = wr_fire && (wr_addr_ff == `LPMC_ADDR_TIME_BASE) && wr_strb_ff[0];
  wire wr_status = wr_fire && (wr_addr_ff == `LPMC_ADDR_STATUS) && wr_strb_ff[0];

  reg [3:0] nxt_state;
  reg [7:0] nxt_mode_two;
  reg [7:0] nxt_stop_ctrl;
  reg [23:0] nxt_warm_cnt;
  reg nxt_warm_slow;
  reg nxt_tb_armed;
  always @* begin
    nxt_state = state_ff;
    nxt_mode_two = wr_mode_two ? wr_data_ff[7:0] : mode_two_ff;
    nxt_stop_ctrl = wr_stop_ctrl ? {wr_data_ff[7:2], 2'b00} : stop_ctrl_ff;
    nxt_warm_cnt = warm_cnt_ff;
    nxt_warm_slow = warm_slow_ff;
    nxt_tb_armed = tb_armed_ff;
    set_tb_latch = 1'b0;
    case (state_ff)
      ST_NORM1, ST_NORM2, ST_SLOW_FAST_OSC_OFF, ST_SLOW_FAST_OSC_ON: begin
        if (stop_ctrl_ff[`LPMC_BIT_STOP]) begin
          nxt_warm_slow = stop_ctrl_ff[`LPMC_BIT_RETURN_MODE]; // [R13] [R16]
          nxt_warm_cnt = wu_count(stop_ctrl_ff[`LPMC_BIT_WUT_HI:`LPMC_BIT_WUT_LO],
                                  stop_ctrl_ff[`LPMC_BIT_RETURN_MODE]); // [R15]
          if (level_rel && stop_lvl_ff)
            nxt_state = ST_WARM; // [R24]
          else
            nxt_state = ST_STOP; // [R10]
        end else if (mode_two_ff[`LPMC_BIT_TIMING_GEN_HALT]) begin
          nxt_tb_armed = time_base_ff[`LPMC_BIT_TBEN]; // [R8] [R9]
          if (state_ff == ST_SLOW_FAST_OSC_OFF || state_ff == ST_SLOW_FAST_OSC_ON)
            nxt_state = ST_TGSLP; // [R5]
          else
            nxt_state = ST_TGIDLE;
        end else if (mode_two_ff[`LPMC_BIT_IDLE]) begin
          case (state_ff)
            ST_NORM1: nxt_state = ST_FIRST_IDLE;
            ST_NORM2: nxt_state = ST_SECOND_IDLE;
            ST_SLOW_FAST_OSC_OFF: nxt_state = ST_SLP1; // [R1] [R2]
            default: nxt_state = ST_SLP2; // [R4]
          endcase
        end else if (mode_two_ff[`LPMC_BIT_SYSCK]) begin
          nxt_state = mode_two_ff[`LPMC_BIT_XEN] ? ST_SLOW_FAST_OSC_ON : ST_SLOW_FAST_OSC_OFF;
        end else begin
          nxt_state = mode_two_ff[`LPMC_BIT_XTEN] ? ST_NORM2 : ST_NORM1;
        end
      end
      ST_FIRST_IDLE, ST_SECOND_IDLE, ST_SLP1, ST_SLP2: begin
        if (irq_lvl_ff) begin
          nxt_mode_two[`LPMC_BIT_IDLE] = 1'b0; // [R22]
          case (state_ff)
            ST_FIRST_IDLE: nxt_state = ST_NORM1;
            ST_SECOND_IDLE: nxt_state = ST_NORM2;
            ST_SLP1: nxt_state = ST_SLOW_FAST_OSC_OFF; // [R2]
            default: nxt_state = ST_SLOW_FAST_OSC_ON;
          endcase
        end
      end
      ST_TGIDLE, ST_TGSLP: begin
        if (tb_fall) begin
          nxt_mode_two[`LPMC_BIT_TIMING_GEN_HALT] = 1'b0; // [R23]
          nxt_state = (state_ff == ST_TGSLP) ? ST_SLOW_FAST_OSC_OFF : ST_NORM1; // [R7]
          set_tb_latch = tb_armed_ff; // [R9]
        end
      end
      ST_STOP: begin
        if (stop_release)
          nxt_state = ST_WARM; // [R11]
      end
      default: begin
        if (warm_cnt_ff <= 24'h000001) begin
          nxt_stop_ctrl[`LPMC_BIT_STOP] = 1'b0;
          nxt_state = warm_slow_ff ? ST_SLOW_FAST_OSC_OFF : ST_NORM1; // [R13]
        end else if (warm_slow_ff ? i_slow_clk_en : i_fast_clk_en) begin
          nxt_warm_cnt = warm_cnt_ff - 24'h000001; // [R15]
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-base irq latch: hardware set wins over software clear
  wire clr_tb_latch = wr_status && wr_data_ff[0];
  wire nxt_tb_latch = set_tb_latch || (o_time_base_irq_latch && !clr_tb_latch);

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff <= ST_NORM1; // [R17]
      stop_ctrl_ff <= `LPMC_STOP_CTRL_RST;
      mode_two_ff <= `LPMC_MODE_TWO_RST;
      time_base_ff <= 8'h00;
      warm_cnt_ff <= 24'h000000;
      warm_slow_ff <= 1'b0;
      tb_armed_ff <= 1'b0;
      tb_prev_ff <= 1'b0;
      stop_prev_ff <= 1'b0;
      o_time_base_irq_latch <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stop_ctrl_ff <= nxt_stop_ctrl;
      mode_two_ff <= nxt_mode_two;
      if (wr_time_base)
        time_base_ff <= wr_data_ff[7:0];
      warm_cnt_ff <= nxt_warm_cnt;
      warm_slow_ff <= nxt_warm_slow;
      tb_armed_ff <= nxt_tb_armed;
      tb_prev_ff <= tb_lvl_ff;
      stop_prev_ff <= stop_lvl_ff;
      o_time_base_irq_latch <= nxt_tb_latch; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock and port controls, all registered from the next state
  wire n_stop = (nxt_state == ST_STOP);
  wire n_tg = (nxt_state == ST_TGIDLE) || (nxt_state == ST_TGSLP);
  wire n_slowish = (nxt_state == ST_SLOW_FAST_OSC_OFF) || (nxt_state == ST_SLP1) || (nxt_state == ST_TGSLP);
  wire n_cpu = (nxt_state == ST_NORM1) || (nxt_state == ST_NORM2) ||
               (nxt_state == ST_SLOW_FAST_OSC_OFF) || (nxt_state == ST_SLOW_FAST_OSC_ON);
  wire n_fast = !n_stop && !(nxt_state == ST_SLOW_FAST_OSC_OFF || nxt_state == ST_SLP1 || nxt_state == ST_TGSLP); // [R1] [R4]
  wire n_slow = !n_stop && (nxt_state != ST_NORM1) && (nxt_state != ST_FIRST_IDLE) && (nxt_state != ST_TGIDLE);
  wire n_hiz = n_stop && !nxt_stop_ctrl[`LPMC_BIT_HOLD];
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_fast_osc_en <= 1'b1;
      o_slow_osc_en <= 1'b0;
      o_cpu_run <= 1'b1;
      o_wdt_run <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_time_base_clk_en <= 1'b1;
      o_div_low_run <= 1'b1;
      o_port_out_en <= 1'b1;
      o_stop_pin_oe <= 1'b1;
      o_port_in_val <= 8'h00;
      o_time_base_irq <= 1'b0;
      o_mode <= ST_NORM1;
    end else begin
      o_fast_osc_en <= n_fast; // [R10]
      o_slow_osc_en <= n_slow; // [R1]
      o_cpu_run <= n_cpu; // [R1] [R5]
      o_wdt_run <= n_cpu;
      o_periph_clk_en <= !n_stop && !n_tg; // [R5] [R6]
      o_time_base_clk_en <= !n_stop; // [R6]
      o_div_low_run <= !n_stop && !n_slowish; // [R3]
      o_port_out_en <= !n_hiz; // [R14]
      o_stop_pin_oe <= !n_stop; // [R21]
      // Bits where stages two and three disagree keep their last value
      o_port_in_val <= n_hiz ? 8'h00 : ((port_s2_ff & port_s3_ff) | (o_port_in_val & (port_s2_ff | port_s3_ff))); // [R19]
      // Irq follows the latch's next value so it never outlives a cleared latch
      o_time_base_irq <= nxt_tb_latch && time_base_ff[`LPMC_BIT_MIE] &&
                         time_base_ff[`LPMC_BIT_TBIE] && time_base_ff[`LPMC_BIT_TBEN]; // [R8]
      o_mode <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPMC_RESP_OKAY;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 32'h00000000;
      wr_strb_ff <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_ff && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !w_have_ff && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        wr_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wr_data_ff <= s_axi_wdata;
        wr_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_addr_ff == `LPMC_ADDR_STOP_CTRL || wr_addr_ff == `LPMC_ADDR_MODE_TWO ||
            wr_addr_ff == `LPMC_ADDR_TIME_BASE || wr_addr_ff == `LPMC_ADDR_STATUS)
          s_axi_bresp <= `LPMC_RESP_OKAY;
        else
          s_axi_bresp <= `LPMC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LPMC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `LPMC_RESP_OKAY;
        if (rd_addr == `LPMC_ADDR_STOP_CTRL)
          s_axi_rdata <= {24'h000000, stop_ctrl_ff[7:2], 2'b00}; // [R18]
        else if (rd_addr == `LPMC_ADDR_MODE_TWO)
          s_axi_rdata <= {24'h000000, mode_two_ff[7:4], 1'b0, mode_two_ff[2], 2'b00};
        else if (rd_addr == `LPMC_ADDR_TIME_BASE)
          s_axi_rdata <= {24'h000000, time_base_ff};
        else if (rd_addr == `LPMC_ADDR_STATUS)
          s_axi_rdata <= {24'h000000, state_ff, 3'h0, o_time_base_irq_latch};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `LPMC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
